// ==== inc/pcc_cfg.svh ====
/*
 Offsets, field positions and reset values of the PWM cycle configuration block.
 Assumes an 8-bit special-function register bus with paged addressing.
*/
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH

`define PCC_CFG_ADDR 8'hd9
`define PCC_CFG_PAGE 8'h0f
`define PCC_CMP_PAGE 8'h00
`define PCC_CMP_LO_BASE 8'he0
`define PCC_CMP_HI_BASE 8'he8
`define PCC_BIT_AUTO_RELOAD_SELECT 7
`define PCC_BIT_CYCLE_OVERFLOW_IRQ_ENABLE 6
`define PCC_BIT_CYCLE_OVERFLOW_FLAG 5
`define PCC_CFG_RESET 8'h00
`define PCC_CFG_RMASK 8'he3
`define PCC_RELOAD_RESET 16'h0000

`endif

// ==== inc/pcc_pkg.sv ====
/*
 Types shared by the PWM cycle configuration block.
 Assumes nothing beyond the constants header.
*/
package pcc_pkg;
    typedef enum logic [1:0] {
        PCC_LEN8 = 2'h0,
        PCC_LEN9 = 2'h1,
        PCC_LEN10 = 2'h2,
        PCC_LEN11 = 2'h3
    } pcc_cycle_len_t;
endpackage : pcc_pkg

// ==== inc/pcc_reload_if.sv ====
/*
 Access path between the configuration logic and the auto-reload bank.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface pcc_reload_if #(parameter int NUM_MODULES = 6) ();
    logic wrEn;
    logic wrHigh;
    logic [2:0] idx;
    logic [7:0] wrData;
    logic rdHigh;
    logic [7:0] rdData;
    logic [NUM_MODULES*16-1:0] values;
    modport ctrl(output wrEn, output wrHigh, output idx, output wrData, output rdHigh,
        input rdData, input values);
    modport bank(input wrEn, input wrHigh, input idx, input wrData, input rdHigh,
        output rdData, output values);
endinterface : pcc_reload_if

// ==== rtl/pcc_cycle_ctrl.sv ====
/*
 PWM cycle configuration register, cycle overflow flag and interrupt request,
 and steering of compare-value accesses to the auto-reload bank.
 Assumes the main counter, compare registers and interrupt controller sit outside
 on the same clock, and that the bus issues one-cycle read and write strobes.
*/
// Notes on behaviour
// - The auto-reload select bit sends compare-value accesses to the reload bank when 1, to the compare registers when 0.
// - Reload values are applied only to channels running a 9, 10 or 11-bit cycle and do nothing otherwise.
// - With the overflow interrupt enable set, a set overflow flag requests the array interrupt; cleared, it does not.
// - The overflow flag sets when the counter carries out of the bit that ends the selected cycle length.
// - The overflow flag is set by hardware or a written 1, never cleared by hardware, and cleared by a written 0.
// - Bits 4 to 2 of the configuration register read as zero and ignore writes.
// - Cycle length select 00, 01 and 10 give 8, 9 and 10-bit cycles.
// - The selected length applies to all non-16-bit PWM channels and is ignored by 16-bit ones.
// - A module's wide enable picks a 16-bit cycle for that module, otherwise the shared length.
`timescale 1ns/1ps
`include "pcc_cfg.svh"
module pcc_cycle_ctrl import pcc_pkg::*; #(
    parameter int NUM_MODULES = 6
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrPage,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    output logic sfrRdHit,
    output logic cmpWrite,
    output logic [2:0] cmpWriteIdx,
    output logic cmpWriteHigh,
    output logic [7:0] cmpWriteData,
    input wire logic [15:0] counterValue,
    input wire logic counterTick,
    input wire logic [NUM_MODULES-1:0] modulePwmEnable,
    input wire logic [NUM_MODULES-1:0] moduleWideEnable,
    output logic [1:0] cycleLengthSel,
    output logic cycleOverflowFlag,
    output logic irqRequest,
    output logic [NUM_MODULES-1:0] reloadLoad,
    output logic [NUM_MODULES-1:0] wideMode,
    output logic [NUM_MODULES*16-1:0] reloadValue
);
    if (NUM_MODULES < 1 || NUM_MODULES > 8) begin : g_check
        $error("NUM_MODULES must lie between 1 and 8");
    end

    function automatic logic [10:0] cycleMask(input logic [1:0] sel);
        case (pcc_cycle_len_t'(sel))
            PCC_LEN8: cycleMask = 11'h0ff;
            PCC_LEN9: cycleMask = 11'h1ff;
            PCC_LEN10: cycleMask = 11'h3ff;
            PCC_LEN11: cycleMask = 11'h7ff;
            default: cycleMask = 11'h0ff;
        endcase
    endfunction : cycleMask

    function automatic logic inBank(input logic [7:0] addr, input logic [7:0] base);
        inBank = (addr >= base) && ({24'h0, addr - base} < NUM_MODULES);
    endfunction : inBank

    function automatic logic [2:0] bankIndex(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] diff;
        diff = addr - base;
        bankIndex = diff[2:0];
    endfunction : bankIndex

    logic [7:0] cfgReg;
    logic [7:0] next_cfgReg;

    pcc_reload_if #(.NUM_MODULES(NUM_MODULES)) rl ();

    pcc_reload_bank #(.NUM_MODULES(NUM_MODULES)) u_bank (
        .mclk(mclk),
        .srst(srst),
        .rl(rl)
    );

    wire autoReloadSelect = cfgReg[`PCC_BIT_AUTO_RELOAD_SELECT];
    wire cycleOverflowIrqEnable = cfgReg[`PCC_BIT_CYCLE_OVERFLOW_IRQ_ENABLE];
    wire cmpPageHit = (sfrPage == `PCC_CMP_PAGE);
    wire cmpLoHit = cmpPageHit && inBank(sfrAddr, `PCC_CMP_LO_BASE);
    wire cmpHiHit = cmpPageHit && inBank(sfrAddr, `PCC_CMP_HI_BASE);
    wire cmpHit = cmpLoHit || cmpHiHit;
    wire [2:0] cmpIdx = cmpLoHit ? bankIndex(sfrAddr, `PCC_CMP_LO_BASE) : bankIndex(sfrAddr, `PCC_CMP_HI_BASE);
    wire cfgHit = (sfrPage == `PCC_CFG_PAGE) && (sfrAddr == `PCC_CFG_ADDR);
    wire cfgWrite = sfrWrite && cfgHit;
    wire reloadAccess = cmpHit && autoReloadSelect;
    wire [10:0] lenMask = cycleMask(cfgReg[1:0]);
    wire cycleWrap = counterTick && ((counterValue[10:0] & lenMask) == lenMask);
    wire [7:0] cfgReadValue = cfgReg & `PCC_CFG_RMASK;
    wire [NUM_MODULES-1:0] next_wideMode = modulePwmEnable & moduleWideEnable;
    wire [NUM_MODULES-1:0] next_reloadLoad =
        modulePwmEnable & ~moduleWideEnable & {NUM_MODULES{cfgReg[1:0] != 2'h0}};

    assign rl.wrEn = sfrWrite && reloadAccess;
    assign rl.wrHigh = cmpHiHit;
    assign rl.idx = cmpIdx;
    assign rl.wrData = sfrWdata;
    assign rl.rdHigh = cmpHiHit;

    always_comb begin
        next_cfgReg = cfgReg;
        if (cfgWrite) begin
            next_cfgReg = sfrWdata & `PCC_CFG_RMASK;
        end
        // Hardware set wins over a software clear in the same cycle
        if (cycleWrap) begin
            next_cfgReg[`PCC_BIT_CYCLE_OVERFLOW_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cfgReg <= `PCC_CFG_RESET;
            irqRequest <= 1'b0;
        end else begin
            cfgReg <= next_cfgReg;
            irqRequest <= next_cfgReg[`PCC_BIT_CYCLE_OVERFLOW_IRQ_ENABLE] && next_cfgReg[`PCC_BIT_CYCLE_OVERFLOW_FLAG];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            sfrRdata <= 8'h00;
            sfrRdHit <= 1'b0;
        end else begin
            sfrRdHit <= sfrRead && (cfgHit || reloadAccess);
            sfrRdata <= !sfrRead ? 8'h00 : cfgHit ? cfgReadValue : reloadAccess ? rl.rdData : 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cmpWrite <= 1'b0;
            cmpWriteIdx <= 3'h0;
            cmpWriteHigh <= 1'b0;
            cmpWriteData <= 8'h00;
        end else begin
            cmpWrite <= sfrWrite && cmpHit && !autoReloadSelect;
            cmpWriteIdx <= cmpIdx;
            cmpWriteHigh <= cmpHiHit;
            cmpWriteData <= sfrWdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            reloadLoad <= '0;
            wideMode <= '0;
            reloadValue <= '0;
        end else begin
            reloadLoad <= next_reloadLoad;
            wideMode <= next_wideMode;
            reloadValue <= rl.values;
        end
    end

    assign cycleLengthSel = cfgReg[1:0];
    assign cycleOverflowFlag = cfgReg[`PCC_BIT_CYCLE_OVERFLOW_FLAG];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_sw_clear;
        cfgWrite && !sfrWdata[`PCC_BIT_CYCLE_OVERFLOW_FLAG] && !cycleWrap;
    endsequence

    sequence s_flag_held;
        cycleOverflowFlag && !(cfgWrite && !sfrWdata[`PCC_BIT_CYCLE_OVERFLOW_FLAG]);
    endsequence

    sequence s_set_and_clear;
        cycleWrap && cfgWrite && !sfrWdata[`PCC_BIT_CYCLE_OVERFLOW_FLAG];
    endsequence

    a_reserved_read_zero: assert property (sfrRead && cfgHit |=> sfrRdHit && sfrRdata[4:2] == 3'h0)
        else $error("Reserved bits not zero");
    a_wrap_sets_flag: assert property (cycleWrap |=> cycleOverflowFlag)
        else $error("Overflow did not set flag");
    a_flag_no_hw_clear: assert property (s_flag_held |=> cycleOverflowFlag)
        else $error("Flag cleared without a software write of 0");
    a_flag_sw_clear: assert property (s_sw_clear |=> !cycleOverflowFlag)
        else $error("Software clear ignored");
    a_irq_follows_flag: assert property (cycleWrap && cycleOverflowIrqEnable && !cfgWrite |=> irqRequest)
        else $error("Enabled overflow gave no interrupt");
    a_irq_masked_off: assert property (!cycleOverflowIrqEnable |-> !irqRequest)
        else $error("Masked flag raised interrupt");
    a_steer_ordinary: assert property (sfrWrite && cmpHit |=> cmpWrite == !$past(autoReloadSelect))
        else $error("Compare write steered wrongly");
    a_nine_no_early: assert property (counterTick && cfgReg[1:0] == 2'h1 && counterValue[8:0] == 9'h0ff
        && !cycleOverflowFlag && !cfgWrite |=> !cycleOverflowFlag)
        else $error("Nine-bit cycle wrapped at eight bits");
    a_eight_wrap: assert property (counterTick && cfgReg[1:0] == 2'h0 && counterValue[7:0] == 8'hff
        |=> cycleOverflowFlag)
        else $error("Eight-bit cycle missed overflow");
    a_ten_wrap: assert property (counterTick && cfgReg[1:0] == 2'h2 && counterValue[9:0] == 10'h3ff
        |=> cycleOverflowFlag)
        else $error("Ten-bit cycle missed overflow");
    a_eleven_wrap: assert property (counterTick && cfgReg[1:0] == 2'h3 && counterValue[10:0] == 11'h7ff
        |=> cycleOverflowFlag)
        else $error("Eleven-bit cycle missed overflow");
    a_wide_ignores_len: assert property (modulePwmEnable[0] && moduleWideEnable[0]
        |=> wideMode[0] && !reloadLoad[0])
        else $error("Wide channel used shared length");
    a_reload_scope: assert property (reloadLoad != '0 |-> $past(cycleLengthSel) != 2'h0)
        else $error("Reload applied in eight-bit cycle");
    a_sw_set_flag: assert property (cfgWrite && sfrWdata[`PCC_BIT_CYCLE_OVERFLOW_FLAG] |=> cycleOverflowFlag)
        else $error("Software set of flag ignored");
    a_set_beats_clear: assert property (s_set_and_clear |=> cycleOverflowFlag)
        else $error("Software clear beat a hardware set");
    a_unmapped_silent: assert property (sfrRead && !cfgHit && !reloadAccess |=> !sfrRdHit && sfrRdata == 8'h00)
        else $error("Unmapped read answered");
    a_reload_read_back: assert property (sfrRead && reloadAccess |=> sfrRdHit && sfrRdata == $past(rl.rdData))
        else $error("Reload read returned wrong byte");
    a_reserved_stay_zero: assert property (cfgReg[4:2] == 3'h0)
        else $error("Reserved bits stored");
    a_irq_level: assert property (irqRequest == (cycleOverflowIrqEnable && cycleOverflowFlag))
        else $error("Interrupt request does not follow enabled flag");
endmodule : pcc_cycle_ctrl

// ==== rtl/pcc_reload_bank.sv ====
/*
 Auto-reload value bank, one 16-bit word per capture/compare module.
 Assumes the controller only writes when the auto-reload select bit is set.
*/
`timescale 1ns/1ps
`include "pcc_cfg.svh"
module pcc_reload_bank import pcc_pkg::*; #(
    parameter int NUM_MODULES = 6
) (
    input wire logic mclk,
    input wire logic srst,
    pcc_reload_if.bank rl
);
    if (NUM_MODULES < 1 || NUM_MODULES > 8) begin : g_check
        $error("NUM_MODULES must lie between 1 and 8");
    end

    logic [15:0] reloadMem [NUM_MODULES];
    wire idxValid = ({29'h0, rl.idx} < NUM_MODULES);
    wire [15:0] selWord = idxValid ? reloadMem[rl.idx] : 16'h0000;

    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < NUM_MODULES; i++) begin
                reloadMem[i] <= `PCC_RELOAD_RESET;
            end
        end else if (rl.wrEn && idxValid) begin
            if (rl.wrHigh) begin
                reloadMem[rl.idx][15:8] <= rl.wrData;
            end else begin
                reloadMem[rl.idx][7:0] <= rl.wrData;
            end
        end
    end

    assign rl.rdData = rl.rdHigh ? selWord[15:8] : selWord[7:0];

    for (genvar g = 0; g < NUM_MODULES; g++) begin : g_out
        assign rl.values[g*16 +: 16] = reloadMem[g];
    end

    a_reload_store_low: assert property (@(posedge mclk) disable iff (srst)
        rl.wrEn && idxValid && !rl.wrHigh |=> reloadMem[$past(rl.idx)][7:0] == $past(rl.wrData))
        else $error("Reload low byte not stored");
endmodule : pcc_reload_bank

// ==== tb/tb.sv ====
/*
 Self-checking bench for the PWM cycle configuration block, with a small register model.
 Assumes the block's assertions sit in the design files and that it holds its own reload bank.
*/
`timescale 1ns/1ps
`include "pcc_cfg.svh"
module tb import pcc_pkg::*; ();
    localparam int N = 6;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sfrAddr = 8'h00, sfrPage = 8'h00, sfrWdata = 8'h00, sfrRdata, cmpWriteData;
    logic sfrWrite = 1'b0, sfrRead = 1'b0, counterTick = 1'b0;
    logic sfrRdHit, cmpWrite, cmpWriteHigh, cycleOverflowFlag, irqRequest;
    logic [2:0] cmpWriteIdx;
    logic [15:0] counterValue = 16'h0000;
    logic [N-1:0] modulePwmEnable = '0, moduleWideEnable = '0, reloadLoad, wideMode;
    logic [1:0] cycleLengthSel;
    logic [N*16-1:0] reloadValue;
    int miscompares = 0, samples_checked = 0, cyc = 0, cfg = 0, m = 0;
    logic [15:0] rl [8];
    logic [7:0] d;

    pcc_cycle_ctrl #(.NUM_MODULES(N)) u_pcc_cycle_ctrl (.mclk(mclk), .srst(srst), .sfrAddr(sfrAddr),
        .sfrPage(sfrPage), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .sfrRdHit(sfrRdHit), .cmpWrite(cmpWrite), .cmpWriteIdx(cmpWriteIdx), .cmpWriteHigh(cmpWriteHigh),
        .cmpWriteData(cmpWriteData), .counterValue(counterValue), .counterTick(counterTick),
        .modulePwmEnable(modulePwmEnable), .moduleWideEnable(moduleWideEnable),
        .cycleLengthSel(cycleLengthSel), .cycleOverflowFlag(cycleOverflowFlag), .irqRequest(irqRequest),
        .reloadLoad(reloadLoad), .wideMode(wideMode), .reloadValue(reloadValue));

    always #25 mclk = ~mclk;

    task automatic end_of_test();
        $display("Counts: %0d compared, %0d mismatched", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // Hang guard, far above the roughly 160 cycles the tests need
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] dat);
        logic isCmp;
        isCmp = p == `PCC_CMP_PAGE && (a[7:3] == 5'h1c || a[7:3] == 5'h1d) && a[2:0] < N;
        @(negedge mclk);
        sfrAddr = a;
        sfrPage = p;
        sfrWdata = dat;
        sfrWrite = 1'b1;
        @(negedge mclk);
        sfrWrite = 1'b0;
        if (a == `PCC_CFG_ADDR && p == `PCC_CFG_PAGE) cfg = dat & 8'he3;
        chk("cmpWrite", cmpWrite, isCmp && !cfg[7]);
        if (isCmp && !cfg[7]) begin
            chk("cmpWriteIdx", cmpWriteIdx, a[2:0]);
            chk("cmpWriteHigh", cmpWriteHigh, a[3]);
            chk("cmpWriteData", cmpWriteData, dat);
        end
        if (isCmp && cfg[7] && a[3]) rl[a[2:0]][15:8] = dat;
        if (isCmp && cfg[7] && !a[3]) rl[a[2:0]][7:0] = dat;
        chk("cycleOverflowFlag", cycleOverflowFlag, cfg[5]);
        chk("irqRequest", irqRequest, cfg[6] & cfg[5]);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] exp, input logic hit);
        @(negedge mclk);
        sfrAddr = a;
        sfrPage = p;
        sfrRead = 1'b1;
        @(negedge mclk);
        sfrRead = 1'b0;
        chk("sfrRdHit", sfrRdHit, hit);
        chk("sfrRdata", sfrRdata, exp);
    endtask : rd

    task automatic tick(input logic [15:0] v);
        @(negedge mclk);
        counterValue = v;
        counterTick = 1'b1;
        @(negedge mclk);
        counterTick = 1'b0;
        if ((v & m) == m) cfg = cfg | 8'h20;
        chk("cycleOverflowFlag", cycleOverflowFlag, cfg[5]);
        chk("irqRequest", irqRequest, cfg[6] & cfg[5]);
    endtask : tick

    task automatic modes();
        @(negedge mclk);
        modulePwmEnable = N'($urandom);
        moduleWideEnable = N'($urandom);
        @(negedge mclk);
        chk("wideMode", wideMode, modulePwmEnable & moduleWideEnable);
        chk("reloadLoad", reloadLoad, (cfg & 3) != 0 ? modulePwmEnable & ~moduleWideEnable : 0);
        chk("cycleLengthSel", cycleLengthSel, cfg & 3);
    endtask : modes

    initial begin
        void'($urandom(26967));
        foreach (rl[i]) rl[i] = `PCC_RELOAD_RESET;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        rd(`PCC_CFG_ADDR, `PCC_CFG_PAGE, `PCC_CFG_RESET, 1'b1);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            d = 8'(($urandom & 8'h9c) | ((k & 1) << 6) | k);
            wr(`PCC_CFG_ADDR, `PCC_CFG_PAGE, d);
            rd(`PCC_CFG_ADDR, `PCC_CFG_PAGE, 8'(cfg), 1'b1);
            modes();
            m = (1 << (8 + k)) - 1;
            // Bit L-1 clear: one count short of the carry into bit L-1
            tick(16'(($urandom & ~m) | (m >> 1)));
            tick(16'(($urandom & ~m) | m));
            tick(16'(($urandom & ~m) | (m >> 1)));
            wr(`PCC_CFG_ADDR, `PCC_CFG_PAGE, d);
            wr(`PCC_CFG_ADDR, `PCC_CFG_PAGE, d | 8'h20);
            rd(`PCC_CFG_ADDR, `PCC_CFG_PAGE, 8'(cfg), 1'b1);
        end
        // Hardware set and software clear in one cycle: the set wins
        @(negedge mclk);
        counterValue = 16'hffff;
        counterTick = 1'b1;
        sfrAddr = `PCC_CFG_ADDR;
        sfrPage = `PCC_CFG_PAGE;
        sfrWdata = 8'h00;
        sfrWrite = 1'b1;
        @(negedge mclk);
        counterTick = 1'b0;
        sfrWrite = 1'b0;
        cfg = 8'h20;
        chk("cycleOverflowFlag", cycleOverflowFlag, cfg[5]);
        chk("irqRequest", irqRequest, cfg[6] & cfg[5]);
        chk("cycleLengthSel", cycleLengthSel, cfg & 3);
        $display("test cycle length and overflow done");
        wr(`PCC_CFG_ADDR, `PCC_CFG_PAGE, 8'h81);
        for (int i = 0; i < N; i++) begin
            wr(8'(`PCC_CMP_LO_BASE + i), `PCC_CMP_PAGE, 8'($urandom));
            wr(8'(`PCC_CMP_HI_BASE + i), `PCC_CMP_PAGE, 8'($urandom));
        end
        @(negedge mclk);
        for (int i = 0; i < N; i++) begin
            chk("reloadValue", reloadValue[16*i +: 16], rl[i]);
            rd(8'(`PCC_CMP_HI_BASE + i), `PCC_CMP_PAGE, rl[i][15:8], 1'b1);
            rd(8'(`PCC_CMP_LO_BASE + i), `PCC_CMP_PAGE, rl[i][7:0], 1'b1);
        end
        rd(8'(`PCC_CMP_LO_BASE + N), `PCC_CMP_PAGE, 8'h00, 1'b0);
        modes();
        wr(`PCC_CFG_ADDR, `PCC_CFG_PAGE, 8'h00);
        modes();
        wr(8'(`PCC_CMP_HI_BASE + 2), `PCC_CMP_PAGE, 8'h5a);
        wr(`PCC_CMP_LO_BASE, `PCC_CMP_PAGE, 8'ha5);
        @(negedge mclk);
        rd(`PCC_CMP_LO_BASE, `PCC_CMP_PAGE, 8'h00, 1'b0);
        for (int i = 0; i < N; i++) chk("reloadValue", reloadValue[16*i +: 16], rl[i]);
        $display("test reload steering done");
        wr(`PCC_CFG_ADDR, `PCC_CMP_PAGE, 8'hff);
        rd(`PCC_CFG_ADDR, `PCC_CMP_PAGE, 8'h00, 1'b0);
        rd(`PCC_CFG_ADDR, `PCC_CFG_PAGE, 8'(cfg), 1'b1);
        // Load every stored bit so the second reset has something to clear
        wr(`PCC_CFG_ADDR, `PCC_CFG_PAGE, 8'he3);
        @(negedge mclk);
        srst = 1'b1;
        @(negedge mclk);
        srst = 1'b0;
        cfg = 0;
        foreach (rl[i]) rl[i] = `PCC_RELOAD_RESET;
        chk("cycleOverflowFlag", cycleOverflowFlag, cfg[5]);
        chk("irqRequest", irqRequest, cfg[6] & cfg[5]);
        chk("cycleLengthSel", cycleLengthSel, cfg & 3);
        rd(`PCC_CFG_ADDR, `PCC_CFG_PAGE, `PCC_CFG_RESET, 1'b1);
        for (int i = 0; i < N; i++) chk("reloadValue", reloadValue[16*i +: 16], rl[i]);
        $display("test unmapped and second reset done");
        end_of_test();
    end
endmodule : tb
